// [core/pcl_pkg.sv]
// Package of offsets, reset values, field layouts and decode tables
package pcl_pkg;

   // Register offsets
   localparam logic [7:0] PCL_OFS_CORE = 8'h0D;
   localparam logic [7:0] PCL_OFS_REGS = 8'h0E;
   localparam logic [7:0] PCL_OFS_PINCFG = 8'h0F;
   localparam logic [7:0] PCL_OFS_PINDV = 8'h10;

   // Values after reset
   localparam logic [7:0] PCL_RST_CORE = 8'h60;
   localparam logic [7:0] PCL_RST_REGS = 8'h88;
   localparam logic [7:0] PCL_RST_PINCFG = 8'h00;
   localparam logic [7:0] PCL_RST_PINDV = 8'h00;
   localparam logic [7:0] PCL_RD_UNMAPPED = 8'h00;

   // Field position of the strap-loaded core voltage bit
   localparam int PCL_STRAP_BIT = 4;

   // Number of general-purpose pins
   localparam int PCL_NPINS = 4;

   // Core converter control layout, bit 7 down to bit 0
   typedef struct packed {
      logic coreOffInSleep;
      logic [2:0] coreVoltageSel;
      logic [1:0] sleepCoreVoltageSel;
      logic vibratorDriveEn;
      logic coreDischargeEn;
   } pcl_core_s;

   // Linear regulator control layout, bit 7 down to bit 0
   typedef struct packed {
      logic regulatorBOn;
      logic regulatorBSleepOff;
      logic [1:0] regulatorBVoltageSel;
      logic regulatorAOn;
      logic regulatorASleepOff;
      logic [1:0] regulatorAVoltageSel;
   } pcl_regs_s;

   // Pin interrupt configuration layout
   typedef struct packed {
      logic [3:0] edgeRising;
      logic [3:0] irqMask;
   } pcl_pincfg_s;

   // Pin direction and value layout
   typedef struct packed {
      logic [3:0] dirOut;
      logic [3:0] value;
   } pcl_pindv_s;

   // Register port request from the serial interface back end
   typedef struct packed {
      logic write;
      logic read;
      logic [7:0] addr;
      logic [7:0] wdata;
   } pcl_req_s;

   // Regulator power state
   typedef enum logic [2:0] {
      PCL_REG_OFF = 3'b001,
      PCL_REG_REDUCED = 3'b010,
      PCL_REG_FULL = 3'b100
   } pcl_regmode_e;

   // Core voltage table in millivolts, index is the 3-bit code
   function automatic logic [11:0] pclCoreMv(input logic [2:0] code);
      unique case (code)
         3'h0: pclCoreMv = 12'd850;
         3'h1: pclCoreMv = 12'd1000;
         3'h2: pclCoreMv = 12'd1100;
         3'h3: pclCoreMv = 12'd1200;
         3'h4: pclCoreMv = 12'd1300;
         3'h5: pclCoreMv = 12'd1400;
         3'h6: pclCoreMv = 12'd1500;
         3'h7: pclCoreMv = 12'd1800;
      endcase
   endfunction : pclCoreMv

   // Regulator B table in millivolts
   function automatic logic [11:0] pclRegBMv(input logic [1:0] code);
      unique case (code)
         2'h0: pclRegBMv = 12'd1800;
         2'h1: pclRegBMv = 12'd2500;
         2'h2: pclRegBMv = 12'd3000;
         2'h3: pclRegBMv = 12'd3300;
      endcase
   endfunction : pclRegBMv

   // Regulator A table in millivolts, zero means external divider
   function automatic logic [11:0] pclRegAMv(input logic [1:0] code);
      unique case (code)
         2'h0: pclRegAMv = 12'd0;
         2'h1: pclRegAMv = 12'd2500;
         2'h2: pclRegAMv = 12'd2750;
         2'h3: pclRegAMv = 12'd3000;
      endcase
   endfunction : pclRegAMv

   // Regulator power state from enable, sleep-off and low power mode
   function automatic pcl_regmode_e pclRegMode(input logic on,
                                               input logic sleepOff,
                                               input logic lowPower);
      if (!on)
         pclRegMode = PCL_REG_OFF;
      else if (!lowPower)
         pclRegMode = PCL_REG_FULL;
      else if (sleepOff)
         pclRegMode = PCL_REG_OFF;
      else
         pclRegMode = PCL_REG_REDUCED;
   endfunction : pclRegMode

endpackage : pcl_pkg

// [core/pcl_regs.sv]
// Core converter, linear regulator and general-purpose pin register slice
// Function
// - Core code decodes to eight ascending voltages
// - Strap pin sets lowest core code bit
// - Host writes override strap-derived core code
// - Core-off-in-sleep turns converter off in sleep
// - Sleep core code: top zero, low from field
// - Leaving sleep restores full normal core code
// - Vibrator transistor follows its drive bit
// - Discharge in wait, or sleep with core off
// - Voltage selection accepted off or with enable; code accepts it in any write
// - Regulator B off, full, reduced or off
// - Regulator A follows same power behaviour
// - Regulator B code selects 1.8 to 3.3 V
// - Regulator A code selects divider to 3.0 V
// - Edge select picks falling or rising interrupt
// - Mask bit suppresses pin interrupt, resets clear
// - Direction bit: zero input, one output
// - Output value one pulls pin low
// - Input pins read level, writes ignored
// - Sleep pin, enable and style enter low power
// - Style zero with pin and enable enters wait
`timescale 1ns/1ps

module pcl_regs
   import pcl_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register port from the serial interface back end
   input wire pcl_req_s regReq,
   output logic [7:0] regRdata,
   output logic regRvalid,
   // Strap and sleep control inputs
   input wire logic coreDefaultStrap,
   input wire logic sleepRequestPin,
   input wire logic sleepFunctionEn,
   input wire logic sleepStyleSel,
   // Core converter controls
   output logic [2:0] coreVoltageCode,
   output logic [11:0] coreMillivolts,
   output logic coreConverterOn,
   output logic coreDischargeOn,
   output logic vibratorDriveOn,
   output logic lowPowerMode,
   output logic waitMode,
   // Linear regulator controls
   output pcl_regmode_e regulatorAMode,
   output logic [11:0] regulatorAMillivolts,
   output pcl_regmode_e regulatorBMode,
   output logic [11:0] regulatorBMillivolts,
   // General-purpose open-drain pins
   input wire logic [3:0] gpioIn,
   output logic [3:0] gpioOut,
   output logic [3:0] gpioOe,
   // Merged pin interrupt pulse
   output logic pinIrq
);

   // Stored registers, one per host-visible offset
   // Core converter control, strap bit patched after reset
   pcl_core_s core_reg;
   // Both linear regulators, enables and codes
   pcl_regs_s regs_reg;
   // Edge select and mask of the four pins
   pcl_pincfg_s pincfg_reg;
   // Direction and stored output value of the four pins
   pcl_pindv_s pindv_reg;

   // Strap capture pending after reset release
   logic strapPending_reg;

   // Pin synchronisers and previous sample
   logic [3:0] pinMeta_reg;
   logic [3:0] pinSync_reg;
   logic [3:0] pinPrev_reg;

   // Write strobes per register
   logic wrCore;
   logic wrRegs;
   logic wrPinCfg;
   logic wrPinDv;

   // Derived mode terms
   logic lowPowerNext;
   logic waitNext;
   logic [2:0] coreCodeNext;
   logic [3:0] pinEvent;
   logic [3:0] pinValueView;
   pcl_pindv_s wrDv;

   // Address decode of the write strobes
   // Only the four mapped offsets decode; any other write is dropped
   // A read in the same cycle as a write sees the old content
   assign wrCore = regReq.write && (regReq.addr == PCL_OFS_CORE);
   assign wrRegs = regReq.write && (regReq.addr == PCL_OFS_REGS);
   assign wrPinCfg = regReq.write && (regReq.addr == PCL_OFS_PINCFG);
   assign wrPinDv = regReq.write && (regReq.addr == PCL_OFS_PINDV);
   assign wrDv = pcl_pindv_s'(regReq.wdata);

   // Core converter control register
   // The strap is taken one edge after reset release, not in reset,
   // so the reset branch stays free of non-constant values
   // A host write in that first cycle takes priority over the strap
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         core_reg <= pcl_core_s'(PCL_RST_CORE);
         strapPending_reg <= 1'b1;
      end
      else
      begin
         strapPending_reg <= 1'b0;
         if (wrCore)
            // Host value wins over the strap
            core_reg <= pcl_core_s'(regReq.wdata);
         else if (strapPending_reg)
            // Strap low gives 1.5 V, high gives 1.8 V
            core_reg[PCL_STRAP_BIT] <= coreDefaultStrap;
      end
   end

   // Linear regulator register, selection taken in any write
   // No guard on the code: a change while enabled is the host's duty
   // Both regulators come out of reset enabled at their default code
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         regs_reg <= pcl_regs_s'(PCL_RST_REGS);
      else if (wrRegs)
         // Enable and voltage land together in one write
         regs_reg <= pcl_regs_s'(regReq.wdata);
   end

   // Pin interrupt configuration register
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         pincfg_reg <= pcl_pincfg_s'(PCL_RST_PINCFG);
      else if (wrPinCfg)
         pincfg_reg <= pcl_pincfg_s'(regReq.wdata);
   end

   // Pin direction and output value register
   // The direction given in the same write decides which value bits
   // land, so a pin turned to output takes its level in one write
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         pindv_reg <= pcl_pindv_s'(PCL_RST_PINDV);
      else if (wrPinDv)
      begin
         pindv_reg.dirOut <= wrDv.dirOut;
         // Value bits of pins left as inputs keep their old content
         for (int i = 0; i < PCL_NPINS; i++)
         begin
            if (wrDv.dirOut[i])
               pindv_reg.value[i] <= wrDv.value[i];
         end
      end
   end

   // Pin synchroniser chain and last sample for edge compare
   // Reset to the pull-up level, so no false edge follows reset
   // Only the second stage feeds edge logic and read-back
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pinMeta_reg <= 4'hF;
         pinSync_reg <= 4'hF;
         pinPrev_reg <= 4'hF;
      end
      else
      begin
         pinMeta_reg <= gpioIn;
         pinSync_reg <= pinMeta_reg;
         pinPrev_reg <= pinSync_reg;
      end
   end

   // Edge qualification per pin
   // An output pin pulled low by this block also makes an edge here;
   // software masks such pins if it does not want the event
   always_comb
   begin
      for (int i = 0; i < PCL_NPINS; i++)
      begin
         if (pincfg_reg.edgeRising[i])
            // Rising edge selected
            pinEvent[i] = pinSync_reg[i] && !pinPrev_reg[i];
         else
            // Falling edge selected
            pinEvent[i] = !pinSync_reg[i] && pinPrev_reg[i];
      end
   end

   // Merged interrupt pulse, one per cycle with a qualifying transition
   // No status is held: edges on several pins in one cycle
   // give a single pulse
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         pinIrq <= 1'b0;
      else
         pinIrq <= |(pinEvent & ~pincfg_reg.irqMask);
   end

   // Input pins show their level, output pins their stored value
   assign pinValueView = (pindv_reg.dirOut & pindv_reg.value) |
                         (~pindv_reg.dirOut & pinSync_reg);

   // Sleep mode selection
   // Style high picks low power, style low picks wait;
   // the two terms can never be true together
   assign lowPowerNext = sleepRequestPin && sleepFunctionEn &&
                         sleepStyleSel;
   assign waitNext = sleepRequestPin && sleepFunctionEn &&
                     !sleepStyleSel;

   // Effective core code for the present mode
   always_comb
   begin
      if (lowPowerNext)
         // Top bit forced low in sleep
         coreCodeNext = {1'b0, core_reg.sleepCoreVoltageSel};
      else
         // Normal code comes straight back after sleep
         coreCodeNext = core_reg.coreVoltageSel;
   end

   // Registered core and mode outputs
   // All outputs follow their inputs one edge later, so that mode
   // flags and the decoded core code always change together
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         coreVoltageCode <= 3'h0;
         coreMillivolts <= 12'h000;
         coreConverterOn <= 1'b0;
         coreDischargeOn <= 1'b0;
         vibratorDriveOn <= 1'b0;
         lowPowerMode <= 1'b0;
         waitMode <= 1'b0;
      end
      else
      begin
         lowPowerMode <= lowPowerNext;
         waitMode <= waitNext;
         coreVoltageCode <= coreCodeNext;
         coreMillivolts <= pclCoreMv(coreCodeNext);
         // Converter is disabled in wait, and in sleep if so chosen
         coreConverterOn <= !waitNext &&
                            !(lowPowerNext && core_reg.coreOffInSleep);
         coreDischargeOn <= core_reg.coreDischargeEn &&
                            (waitNext ||
                             (lowPowerNext && core_reg.coreOffInSleep));
         vibratorDriveOn <= core_reg.vibratorDriveEn;
      end
   end

   // Registered regulator outputs
   // Mode uses the same sleep term as the core outputs, so the
   // regulators and the core converter switch on the same edge
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         regulatorAMode <= PCL_REG_OFF;
         regulatorBMode <= PCL_REG_OFF;
         regulatorAMillivolts <= 12'h000;
         regulatorBMillivolts <= 12'h000;
      end
      else
      begin
         regulatorBMode <= pclRegMode(regs_reg.regulatorBOn,
                                      regs_reg.regulatorBSleepOff,
                                      lowPowerNext);
         regulatorAMode <= pclRegMode(regs_reg.regulatorAOn,
                                      regs_reg.regulatorASleepOff,
                                      lowPowerNext);
         regulatorBMillivolts <=
            pclRegBMv(regs_reg.regulatorBVoltageSel);
         // Host keeps upward steps on A below ten percent
         regulatorAMillivolts <=
            pclRegAMv(regs_reg.regulatorAVoltageSel);
      end
   end

   // Open-drain drive: enable only when pulling low
   // The data side is held at zero; a released pin is left to
   // its external pull-up, never driven high
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         gpioOe <= 4'h0;
         gpioOut <= 4'h0;
      end
      else
      begin
         gpioOe <= pindv_reg.dirOut & pindv_reg.value;
         gpioOut <= 4'h0;
      end
   end

   // Read port, answered the cycle after the read strobe
   // Read data holds until the next read; valid is a single pulse
   // Input pins read their synchronised level, two edges late
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         regRdata <= 8'h00;
         regRvalid <= 1'b0;
      end
      else
      begin
         regRvalid <= regReq.read;
         if (regReq.read)
         begin
            unique case (regReq.addr)
               PCL_OFS_CORE: regRdata <= core_reg;
               PCL_OFS_REGS: regRdata <= regs_reg;
               PCL_OFS_PINCFG: regRdata <= pincfg_reg;
               PCL_OFS_PINDV: regRdata <= {pindv_reg.dirOut, pinValueView};
               // Unmapped offsets read as zero
               default: regRdata <= PCL_RD_UNMAPPED;
            endcase
         end
      end
   end

endmodule : pcl_regs

// [verification/pcl_regs_properties.sv]
// Output property checker for the register slice
`timescale 1ns/1ps

module pcl_regs_properties
   import pcl_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register port and sleep inputs
   input wire pcl_req_s regReq,
   input wire logic sleepRequestPin,
   input wire logic sleepFunctionEn,
   input wire logic sleepStyleSel,
   // Core converter outputs
   input wire logic [2:0] coreVoltageCode,
   input wire logic [11:0] coreMillivolts,
   input wire logic coreConverterOn,
   input wire logic coreDischargeOn,
   input wire logic vibratorDriveOn,
   input wire logic lowPowerMode,
   input wire logic waitMode,
   // Regulator modes
   input wire pcl_regmode_e regulatorAMode,
   input wire pcl_regmode_e regulatorBMode,
   // Pins and interrupt
   input wire logic [3:0] gpioIn,
   input wire logic [3:0] gpioOut,
   input wire logic pinIrq
);
   // Expected core millivolts per code
   localparam logic [11:0] MV_TAB [8] = '{12'd850, 12'd1000, 12'd1100,
      12'd1200, 12'd1300, 12'd1400, 12'd1500, 12'd1800};

   // Single domain
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   a_core_mv_decode: assert property (
      !$past(rst) |-> coreMillivolts == MV_TAB[coreVoltageCode])
      else $error("core millivolts do not match code");
   a_lp_entry: assert property (
      !$past(rst) |-> lowPowerMode ==
         $past(sleepRequestPin && sleepFunctionEn && sleepStyleSel))
      else $error("low power mode not from its inputs");
   a_wait_entry: assert property (
      !$past(rst) |-> waitMode ==
         $past(sleepRequestPin && sleepFunctionEn && !sleepStyleSel))
      else $error("wait mode not from its inputs");
   a_lp_code_top: assert property (
      lowPowerMode |-> !coreVoltageCode[2])
      else $error("top core code bit set in low power");
   a_core_stays_on: assert property (
      !$past(rst) && !lowPowerMode && !waitMode |-> coreConverterOn)
      else $error("core converter off in normal mode");
   a_discharge_cause: assert property (
      coreDischargeOn |-> waitMode || (lowPowerMode && !coreConverterOn))
      else $error("discharge outside wait or sleep off");
   a_vib_follow: assert property (
      regReq.write && regReq.addr == PCL_OFS_CORE |->
         ##2 vibratorDriveOn == $past(regReq.wdata[1], 2))
      else $error("vibrator drive does not follow write");
   a_reg_b_reduced: assert property (
      regulatorBMode == PCL_REG_REDUCED |-> lowPowerMode)
      else $error("regulator B reduced outside low power");
   a_reg_a_full: assert property (
      regulatorAMode == PCL_REG_FULL |-> !lowPowerMode)
      else $error("regulator A full in low power");
   a_pins_open_drain: assert property (gpioOut == 4'h0)
      else $error("pin driven high");
   a_irq_cause: assert property (
      !$past(rst, 4) && pinIrq |-> $past(gpioIn, 3) != $past(gpioIn, 4))
      else $error("pin interrupt without a pin change");

   // Main scenarios
   c_low_power: cover property ($rose(lowPowerMode));
   c_wait: cover property ($rose(waitMode));
   c_irq: cover property (pinIrq);
endmodule : pcl_regs_properties

bind pcl_regs pcl_regs_properties u_chk (.clk(clk), .rst(rst),
   .regReq(regReq), .sleepRequestPin(sleepRequestPin),
   .sleepFunctionEn(sleepFunctionEn), .sleepStyleSel(sleepStyleSel),
   .coreVoltageCode(coreVoltageCode), .coreMillivolts(coreMillivolts),
   .coreConverterOn(coreConverterOn), .coreDischargeOn(coreDischargeOn),
   .vibratorDriveOn(vibratorDriveOn), .lowPowerMode(lowPowerMode),
   .waitMode(waitMode), .regulatorAMode(regulatorAMode),
   .regulatorBMode(regulatorBMode), .gpioIn(gpioIn), .gpioOut(gpioOut),
   .pinIrq(pinIrq));

// [verification/pcl_host_model.sv]
// Host model driving the register port
`timescale 1ns/1ps

module pcl_host_model
   import pcl_pkg::*;
(
   // Clock
   input wire logic clk,
   // Register port
   output pcl_req_s regReq,
   input wire logic [7:0] regRdata,
   input wire logic regRvalid
);
   // Idle port at time zero
   initial regReq = '0;

   // One write strobe; released fields are turned round
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      regReq.write = 1'b1;
      regReq.addr = a;
      regReq.wdata = d;
      @(posedge clk);
      #1;
      regReq.write = 1'b0;
      regReq.addr = ~a;
      regReq.wdata = ~d;
   endtask : wr

   // One read strobe; answer taken one edge later
   task automatic rd(input logic [7:0] a, output logic [7:0] d,
                     output logic v);
      @(posedge clk);
      #1;
      regReq.read = 1'b1;
      regReq.addr = a;
      @(posedge clk);
      #1;
      v = regRvalid;
      d = regRdata;
      regReq.read = 1'b0;
      regReq.addr = ~a;
   endtask : rd
endmodule : pcl_host_model

// [verification/testbench.sv]
// Directed testbench of the register slice
`timescale 1ns/1ps

module testbench;
   import pcl_pkg::*;
   // Clock, reset and port wires
   logic clk = 1'b0;
   logic rst = 1'b1;
   pcl_req_s regReq;
   logic [7:0] regRdata, rdData;
   logic regRvalid, rdOk;
   // Strap and sleep inputs
   logic coreDefaultStrap = 1'b1;
   logic sleepRequestPin = 1'b0;
   logic sleepFunctionEn = 1'b0;
   logic sleepStyleSel = 1'b0;
   // Outputs
   logic [2:0] coreVoltageCode;
   logic [11:0] coreMillivolts, regulatorAMillivolts, regulatorBMillivolts;
   logic coreConverterOn, coreDischargeOn, vibratorDriveOn;
   logic lowPowerMode, waitMode, pinIrq;
   pcl_regmode_e regulatorAMode, regulatorBMode;
   logic [3:0] gpioIn, gpioOut, gpioOe;
   // External pin drivers; high means released to pull-up
   logic [3:0] extLevel = 4'hF;
   int error_cnt = 0;
   int tests_run = 0;
   int pulses;
   // Expected core millivolts per code
   localparam logic [11:0] CORE_MV [8] = '{12'd850, 12'd1000, 12'd1100,
      12'd1200, 12'd1300, 12'd1400, 12'd1500, 12'd1800};

   // Open-drain wire with pull-up
   assign gpioIn = extLevel & ~gpioOe;

   // Clock at 100 ns
   initial
   begin
      forever #50 clk = ~clk;
   end

   pcl_host_model host (.clk(clk), .regReq(regReq), .regRdata(regRdata),
      .regRvalid(regRvalid));

   pcl_regs DUT (.clk(clk), .rst(rst), .regReq(regReq),
      .regRdata(regRdata), .regRvalid(regRvalid),
      .coreDefaultStrap(coreDefaultStrap), .sleepRequestPin(sleepRequestPin),
      .sleepFunctionEn(sleepFunctionEn), .sleepStyleSel(sleepStyleSel),
      .coreVoltageCode(coreVoltageCode), .coreMillivolts(coreMillivolts),
      .coreConverterOn(coreConverterOn), .coreDischargeOn(coreDischargeOn),
      .vibratorDriveOn(vibratorDriveOn), .lowPowerMode(lowPowerMode),
      .waitMode(waitMode), .regulatorAMode(regulatorAMode),
      .regulatorAMillivolts(regulatorAMillivolts),
      .regulatorBMode(regulatorBMode),
      .regulatorBMillivolts(regulatorBMillivolts), .gpioIn(gpioIn),
      .gpioOut(gpioOut), .gpioOe(gpioOe), .pinIrq(pinIrq));

   // Compare one value
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk

   // Read a register and compare
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      host.rd(a, rdData, rdOk);
      chk(12'(rdOk), 12'h001);
      chk(12'(rdData), 12'(e));
   endtask : rdchk

   // Let n edges pass, then settle
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc

   // Set pins, count interrupt pulses over eight cycles
   task automatic irqs(input logic [3:0] lvl, input int e);
      extLevel = lvl;
      pulses = 0;
      repeat (8)
      begin
         cyc(1);
         if (pinIrq === 1'b1)
            pulses++;
      end
      chk(12'(pulses), 12'(e));
   endtask : irqs

   // Verdict and end of run
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : test_done

   // Main sequence
   initial
   begin
      cyc(20);
      rst = 1'b0;
      cyc(2);
      rdchk(PCL_OFS_CORE, 8'h70);
      rdchk(PCL_OFS_REGS, 8'h88);
      rdchk(PCL_OFS_PINCFG, 8'h00);
      rdchk(PCL_OFS_PINDV, 8'h0F);
      rdchk(8'h11, 8'h00);
      chk(coreMillivolts, 12'd1800);
      chk(regulatorAMillivolts, 12'd0);
      chk(regulatorBMillivolts, 12'd1800);
      $display("test reset done");
      for (int c = 0; c < 8; c++)
      begin
         host.wr(PCL_OFS_CORE, {1'b0, 3'(c), 2'b10, c[0], 1'b0});
         cyc(2);
         chk(coreMillivolts, CORE_MV[c]);
         chk(12'(vibratorDriveOn), 12'(c[0]));
      end
      $display("test core codes done");
      host.wr(PCL_OFS_CORE, 8'hF5);
      host.wr(PCL_OFS_REGS, 8'h00);
      host.wr(PCL_OFS_REGS, 8'hDA);
      sleepFunctionEn = 1'b1;
      sleepStyleSel = 1'b1;
      sleepRequestPin = 1'b1;
      cyc(2);
      chk(12'(lowPowerMode), 12'h001);
      chk(12'(coreVoltageCode), 12'h001);
      chk(12'(coreConverterOn), 12'h000);
      chk(12'(coreDischargeOn), 12'h001);
      chk(12'(regulatorBMode), 12'(PCL_REG_OFF));
      chk(12'(regulatorAMode), 12'(PCL_REG_REDUCED));
      chk(regulatorBMillivolts, 12'd2500);
      chk(regulatorAMillivolts, 12'd2750);
      sleepRequestPin = 1'b0;
      cyc(2);
      chk(12'(coreVoltageCode), 12'h007);
      chk(12'(regulatorAMode), 12'(PCL_REG_FULL));
      chk(12'(coreDischargeOn), 12'h000);
      sleepStyleSel = 1'b0;
      sleepRequestPin = 1'b1;
      cyc(2);
      chk(12'(waitMode), 12'h001);
      chk(12'(lowPowerMode), 12'h000);
      chk(12'(coreDischargeOn), 12'h001);
      sleepStyleSel = 1'b1;
      host.wr(PCL_OFS_CORE, 8'h75);
      cyc(2);
      chk(12'(coreConverterOn), 12'h001);
      chk(12'(coreDischargeOn), 12'h000);
      sleepRequestPin = 1'b0;
      $display("test sleep modes done");
      host.wr(PCL_OFS_PINDV, 8'h13);
      cyc(4);
      chk(12'(gpioOe), 12'h001);
      chk(12'(gpioOut), 12'h000);
      rdchk(PCL_OFS_PINDV, 8'h1F);
      irqs(4'hB, 1);
      host.wr(PCL_OFS_PINCFG, 8'h04);
      irqs(4'hF, 0);
      irqs(4'hB, 0);
      host.wr(PCL_OFS_PINCFG, 8'h80);
      irqs(4'h3, 0);
      irqs(4'hF, 1);
      irqs(4'h9, 1);
      extLevel = 4'hF;
      $display("test pins done");
      cyc(4);
      rst = 1'b1;
      coreDefaultStrap = 1'b0;
      cyc(3);
      rst = 1'b0;
      cyc(2);
      rdchk(PCL_OFS_CORE, 8'h60);
      chk(coreMillivolts, 12'd1500);
      $display("test strap low done");
      test_done();
   end
endmodule : testbench
